// ### shared/opc_pkg.sv
// Constants for the oscillator and PLL control block: register offsets,
// field positions, reset values and start-up timing.
// Assumes a 32-bit AXI4-Lite register port with byte addresses.
package opc_pkg;

  // Byte offsets of the registers.
  localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
  localparam logic [7:0] OFF_SLOW_CTRL = 8'h04;
  localparam logic [7:0] OFF_PLL_CTRL  = 8'h08;
  localparam logic [7:0] OFF_UNLOCK    = 8'h0C;
  localparam logic [7:0] OFF_STATUS    = 8'h10;
  localparam logic [7:0] OFF_IER       = 8'h14;
  localparam logic [7:0] OFF_IDR       = 8'h18;
  localparam logic [7:0] OFF_IMR       = 8'h1C;
  localparam logic [7:0] OFF_ISR       = 8'h20;
  localparam logic [7:0] OFF_ICR       = 8'h24;
  localparam logic [7:0] OFF_RC_OUT    = 8'h28;
  localparam logic [7:0] OFF_BOD_CTRL  = 8'h2C;

  // Oscillator control fields, shared by the main and slow oscillators.
  localparam int OSC_EN_BIT     = 0;
  localparam int OSC_MODE_BIT   = 1;
  localparam int OSC_START_LSB  = 8;
  localparam int START_W        = 4;
  // Slow oscillator extra fields.
  localparam int SLOW_KHZ_BIT   = 2;
  localparam int SLOW_32K_BIT   = 3;
  localparam int SLOW_PIN_BIT   = 4;
  // PLL control fields.
  localparam int PLL_EN_BIT     = 0;
  localparam int PLL_SRC_LSB    = 1;
  localparam int PLL_SRC_W      = 2;
  localparam int PLL_MUL_LSB    = 8;
  localparam int PLL_MUL_W      = 4;
  localparam int PLL_DIV_LSB    = 16;
  localparam int PLL_DIV_W      = 4;
  // Unlock register: key in the top byte, target offset in the low byte.
  localparam int UNLOCK_KEY_LSB = 24;
  localparam logic [7:0] UNLOCK_KEY = 8'hAA;

  // Status and event bit positions.
  localparam int ST_MAIN_RDY = 0;
  localparam int ST_SLOW_RDY = 1;
  localparam int ST_PLL_LOCK = 2;
  localparam int ST_PLL_LOST = 3;
  localparam int N_EVT       = 4;
  localparam int BOD_W       = 8;

  // Writable bits and reset values.
  localparam logic [31:0] MAIN_CTRL_MASK = 32'h0000_0F03;
  localparam logic [31:0] SLOW_CTRL_MASK = 32'h0000_0F1F;
  localparam logic [31:0] PLL_CTRL_MASK  = 32'h000F_0F07;
  localparam logic [31:0] MAIN_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] SLOW_CTRL_RST  = 32'h0000_0008;
  localparam logic [31:0] PLL_CTRL_RST   = 32'h0000_0000;
  localparam logic [7:0]  BOD_CTRL_RST   = 8'h00;

  // Start-up time is 2^(field + base) clock cycles.
  localparam logic [4:0] STARTUP_BASE_LOG2 = 5'h04;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### design/opc_top.sv
// Oscillator and PLL control: enables, start-up masking, ready flags,
// interrupt mask, PLL write protection and pin takeover, on AXI4-Lite.
// Assumes all inputs are synchronous to mclk, and that mclk keeps running
// while resetn is held so the brown-out control register can be cleared.
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01 - Main oscillator off after reset, pins free
// R02 - Enabled main oscillator takes over crystal pins
// R03 - External clock drives input pin; output pin free
// R04 - Enable bit starts oscillator; mode bit selects
// R05 - Sleep stops all oscillators except slow one
// R06 - Output masked during programmed start-up time
// R07 - Main ready flag, interrupt on rise when masked
// R08 - Enable register writes one to set mask
// R09 - Software toggles slow enable bit alone
// R10 - Slow oscillator keeps running in sleep
// R11 - Slow start-up field sets masking duration
// R12 - Slow ready flag, interrupt on its rise
// R13 - Slow settings survive all but power-on reset
// R14 - Kilohertz output bit; 32 kHz gate set
// R15 - Pin select chooses primary or alternate pins
// R16 - PLL off after reset until enabled
// R17 - PLL output masked until lock after start
// R18 - PLL register writable only after unlock
// R19 - RC slow clock driven on pin after reset
// R20 - Brown-out control kept on brown-out reset; the bod_control output still reads 0 while reset is held
// R21 - PLL configuration frozen while PLL enabled
// R22 - Lock flag, lock-lost flag, interrupts on rise
// R23 - Disable clears ready until new start-up
module opc_top #(
  parameter int CNT_W = 24
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        por_n,
  input  wire logic        brownout_reset_cause,
  input  wire logic        sleep_osc_off,
  input  wire logic        pll_lock_in,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq,
  output logic             main_osc_run,
  output logic             main_osc_crystal_mode,
  output logic             crystal_in_pin_takeover,
  output logic             crystal_out_pin_takeover,
  output logic             main_clock_gate,
  output logic             slow_osc_run,
  output logic             slow_osc_crystal_mode,
  output logic             slow_primary_pin_takeover,
  output logic             slow_alt_pin_takeover,
  output logic             slow_clock_gate,
  output logic             khz_clock_gate,
  output logic             pll_run,
  output logic [1:0]       pll_ref_select,
  output logic [3:0]       pll_multiplier,
  output logic [3:0]       pll_divider,
  output logic             pll_clock_gate,
  output logic             rc_slow_clock_out_pin_enable,
  output logic [7:0]       bod_control
);

  // Start-up length in cycles for a start-up field value.
  function automatic logic [CNT_W-1:0] startup_limit(
    input logic [3:0] sel
  );
    startup_limit = CNT_W'(1) << ({1'b0, sel} + opc_pkg::STARTUP_BASE_LOG2);
  endfunction

  // True for every offset that answers with OKAY.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= opc_pkg::OFF_BOD_CTRL);
  endfunction

  // Reset synchronisers: assertion is immediate, release is clocked.
  logic rst_meta;
  logic rst_n;
  logic por_meta;
  logic por_rst_n;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      por_meta  <= 1'b0;
      por_rst_n <= 1'b0;
    end else begin
      por_meta  <= 1'b1;
      por_rst_n <= por_meta;
    end
  end

  // Register state.
  logic [31:0]                 ctrl_main;
  logic [31:0]                 ctrl_slow;
  logic [31:0]                 ctrl_pll;
  logic                        unlock_armed;
  logic [opc_pkg::N_EVT-1:0]   interrupt_mask_reg;
  logic [opc_pkg::N_EVT-1:0]   isr;
  logic                        rc_out_en;
  logic [opc_pkg::BOD_W-1:0]   bod_reg;
  logic [1:0]                  osc_ready;
  logic [CNT_W-1:0]            osc_cnt [2];
  logic                        pll_locked;
  logic                        pll_lost;
  logic                        pll_run_q;
  logic [opc_pkg::N_EVT-1:0]   status_q;

  // AXI write holding registers.
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  // Write decode; the write happens once address and data are both held.
  wire         wr_go    = aw_held && w_held && !bvalid;
  wire         wr_ok    = is_mapped(aw_addr);
  wire         wr_main  = wr_go && (aw_addr == opc_pkg::OFF_MAIN_CTRL);
  wire         wr_slow  = wr_go && (aw_addr == opc_pkg::OFF_SLOW_CTRL);
  wire         wr_pll   = wr_go && (aw_addr == opc_pkg::OFF_PLL_CTRL);
  wire         wr_unl   = wr_go && (aw_addr == opc_pkg::OFF_UNLOCK);
  wire         wr_ier   = wr_go && (aw_addr == opc_pkg::OFF_IER);
  wire         wr_idr   = wr_go && (aw_addr == opc_pkg::OFF_IDR);
  wire         wr_icr   = wr_go && (aw_addr == opc_pkg::OFF_ICR);
  wire         wr_rc    = wr_go && (aw_addr == opc_pkg::OFF_RC_OUT);
  wire         wr_bod   = wr_go && (aw_addr == opc_pkg::OFF_BOD_CTRL);
  wire [31:0]  wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}},
                           {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0]  wbits    = w_data & wmask;
  wire         pll_en   = ctrl_pll[opc_pkg::PLL_EN_BIT];
  wire         pll_pass = wr_pll && unlock_armed; // R18
  wire         key_ok   = (w_data[31:24] == opc_pkg::UNLOCK_KEY) &&
                          (w_data[7:0] == opc_pkg::OFF_PLL_CTRL);

  // Byte-lane merge of a control register write.
  wire [31:0] main_wv = ((ctrl_main & ~wmask) | wbits) &
                        opc_pkg::MAIN_CTRL_MASK;
  wire [31:0] slow_wv = ((ctrl_slow & ~wmask) | wbits) &
                        opc_pkg::SLOW_CTRL_MASK;
  wire [31:0] pll_wv  = ((ctrl_pll & ~wmask) | wbits) &
                        opc_pkg::PLL_CTRL_MASK;
  // While enabled only the enable bit may move, so the PLL can be stopped.
  wire [31:0] pll_keep = {ctrl_pll[31:1], pll_wv[opc_pkg::PLL_EN_BIT]};
  wire [31:0] next_pll = pll_en ? pll_keep : pll_wv; // R21

  // Oscillator run requests; sleep stops all but the slow one.
  wire [1:0] osc_run = {ctrl_slow[opc_pkg::OSC_EN_BIT], // R10
                        ctrl_main[opc_pkg::OSC_EN_BIT] && !sleep_osc_off};
  wire [3:0] osc_sel [2];
  assign osc_sel[0] = ctrl_main[opc_pkg::OSC_START_LSB +: opc_pkg::START_W];
  assign osc_sel[1] = ctrl_slow[opc_pkg::OSC_START_LSB +: opc_pkg::START_W];
  wire pll_run_now  = pll_en && !sleep_osc_off; // R05

  // Main and PLL control registers use the ordinary system reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_main    <= opc_pkg::MAIN_CTRL_RST; // R01
      ctrl_pll     <= opc_pkg::PLL_CTRL_RST;  // R16
      unlock_armed <= 1'b0;
      rc_out_en    <= 1'b1;                   // R19
    end else if (wr_go) begin
      if (wr_main) ctrl_main <= main_wv;      // R04
      if (pll_pass) ctrl_pll <= next_pll;     // R18
      unlock_armed <= wr_unl && key_ok;
      if (wr_rc) rc_out_en <= wbits[0];
    end
  end

  // Slow oscillator settings survive every reset except power-on.
  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      ctrl_slow <= opc_pkg::SLOW_CTRL_RST; // R13 R14
    end else if (rst_n && wr_slow) begin
      ctrl_slow <= slow_wv;                // R11 R15
    end
  end

  // Brown-out control: cleared during a system reset unless caused by
  // brown-out. This needs mclk running while reset is held.
  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      bod_reg <= opc_pkg::BOD_CTRL_RST;
    end else if (!rst_n && !brownout_reset_cause) begin
      bod_reg <= opc_pkg::BOD_CTRL_RST;   // R20
    end else if (rst_n && wr_bod) begin
      bod_reg <= wbits[opc_pkg::BOD_W-1:0];
    end
  end

  // Start-up counters: ready rises after exactly startup_limit cycles of
  // running, and drops the cycle after the run request goes away. The slow
  // counter is kept on the power-on reset, like its settings.
  for (genvar g = 0; g < 2; g++) begin : g_osc
    always_ff @(posedge mclk or negedge por_rst_n) begin
      if (!por_rst_n) begin
        osc_cnt[g]   <= '0;
        osc_ready[g] <= 1'b0;
      end else if (!rst_n && (g == 0)) begin
        osc_cnt[g]   <= '0;
        osc_ready[g] <= 1'b0;
      end else if (!osc_run[g]) begin
        osc_cnt[g]   <= '0;                // R23
        osc_ready[g] <= 1'b0;              // R23
      end else if (!osc_ready[g]) begin
        osc_cnt[g]   <= osc_cnt[g] + CNT_W'(1); // R06 R11
        if (osc_cnt[g] == startup_limit(osc_sel[g]) - CNT_W'(1)) begin
          osc_ready[g] <= 1'b1;
        end
      end
    end
  end

  // PLL lock tracking; the first cycle after start ignores a stale lock.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pll_run_q  <= 1'b0;
      pll_locked <= 1'b0;
      pll_lost   <= 1'b0;
    end else begin
      pll_run_q  <= pll_run_now;
      pll_locked <= pll_run_now && pll_run_q && pll_lock_in; // R17 R22
      if (pll_locked && pll_run_now && !pll_lock_in) begin
        pll_lost <= 1'b1;                  // R22
      end else if (wr_icr && wbits[opc_pkg::ST_PLL_LOST]) begin
        pll_lost <= 1'b0;
      end
    end
  end

  // Events are rising edges of status; a set beats a same-cycle clear.
  wire [opc_pkg::N_EVT-1:0] status_now = {pll_lost, pll_locked,
                                          osc_ready[1], osc_ready[0]};
  wire [opc_pkg::N_EVT-1:0] evt_rise   = status_now & ~status_q;
  wire [opc_pkg::N_EVT-1:0] icr_bits   = wr_icr ? wbits[3:0] : 4'h0;
  wire [opc_pkg::N_EVT-1:0] ier_bits   = wr_ier ? wbits[3:0] : 4'h0;
  wire [opc_pkg::N_EVT-1:0] idr_bits   = wr_idr ? wbits[3:0] : 4'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      isr      <= '0;
      interrupt_mask_reg      <= '0;
      irq      <= 1'b0;
    end else begin
      status_q <= status_now;
      isr      <= (isr & ~icr_bits) | evt_rise; // R07 R12 R22
      interrupt_mask_reg      <= (interrupt_mask_reg | ier_bits) & ~idr_bits; // R08
      irq      <= |(isr & interrupt_mask_reg);
    end
  end

  // Register outputs so every pin comes straight from a flip-flop.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      main_osc_run                 <= 1'b0;
      main_osc_crystal_mode        <= 1'b0;
      crystal_in_pin_takeover      <= 1'b0;
      crystal_out_pin_takeover     <= 1'b0;
      main_clock_gate              <= 1'b0;
      pll_run                      <= 1'b0;
      pll_ref_select               <= 2'h0;
      pll_multiplier               <= 4'h0;
      pll_divider                  <= 4'h0;
      pll_clock_gate               <= 1'b0;
      rc_slow_clock_out_pin_enable <= 1'b1;
      bod_control                  <= 8'h00;
    end else begin
      main_osc_run             <= osc_run[0];                  // R05
      main_osc_crystal_mode    <= ctrl_main[opc_pkg::OSC_MODE_BIT];
      crystal_in_pin_takeover  <= ctrl_main[opc_pkg::OSC_EN_BIT]; // R02
      // External clock mode leaves the output pin to general I/O.
      crystal_out_pin_takeover <= ctrl_main[opc_pkg::OSC_EN_BIT] &&
                                  ctrl_main[opc_pkg::OSC_MODE_BIT]; // R03
      main_clock_gate          <= osc_ready[0];                // R06
      pll_run                  <= pll_run_now;                 // R16
      pll_ref_select <= ctrl_pll[opc_pkg::PLL_SRC_LSB +: opc_pkg::PLL_SRC_W];
      pll_multiplier <= ctrl_pll[opc_pkg::PLL_MUL_LSB +: opc_pkg::PLL_MUL_W];
      pll_divider    <= ctrl_pll[opc_pkg::PLL_DIV_LSB +: opc_pkg::PLL_DIV_W];
      pll_clock_gate           <= pll_locked;                  // R17
      rc_slow_clock_out_pin_enable <= rc_out_en;               // R19
      bod_control              <= bod_reg;
    end
  end

  // Slow oscillator output stage. It sits on the power-on reset, so a
  // system reset does not stop a crystal that took long to start.
  always_ff @(posedge mclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      slow_osc_run              <= 1'b0;
      slow_osc_crystal_mode     <= 1'b0;
      slow_primary_pin_takeover <= 1'b0;
      slow_alt_pin_takeover     <= 1'b0;
      slow_clock_gate           <= 1'b0;
      khz_clock_gate            <= 1'b0;
    end else begin
      slow_osc_run              <= osc_run[1];                 // R13
      slow_osc_crystal_mode     <= ctrl_slow[opc_pkg::OSC_MODE_BIT];
      slow_primary_pin_takeover <= osc_run[1] &&
                                   !ctrl_slow[opc_pkg::SLOW_PIN_BIT]; // R15
      slow_alt_pin_takeover     <= osc_run[1] &&
                                   ctrl_slow[opc_pkg::SLOW_PIN_BIT];
      slow_clock_gate           <= osc_ready[1] &&
                                   ctrl_slow[opc_pkg::SLOW_32K_BIT]; // R14
      khz_clock_gate            <= osc_ready[1] &&
                                   ctrl_slow[opc_pkg::SLOW_KHZ_BIT];
    end
  end

  // Read data selection; reserved bits and write-only registers read 0.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (araddr)
      opc_pkg::OFF_MAIN_CTRL: rd_word = ctrl_main;
      opc_pkg::OFF_SLOW_CTRL: rd_word = ctrl_slow;
      opc_pkg::OFF_PLL_CTRL:  rd_word = ctrl_pll;
      opc_pkg::OFF_UNLOCK:    rd_word = {31'h0, unlock_armed};
      opc_pkg::OFF_STATUS:    rd_word = {28'h0, status_now};
      opc_pkg::OFF_IMR:       rd_word = {28'h0, interrupt_mask_reg};
      opc_pkg::OFF_ISR:       rd_word = {28'h0, isr};
      opc_pkg::OFF_RC_OUT:    rd_word = {31'h0, rc_out_en};
      opc_pkg::OFF_BOD_CTRL:  rd_word = {24'h0, bod_reg};
      default:                rd_word = 32'h0000_0000;
    endcase
  end

  // AXI4-Lite write channels: address and data are taken independently,
  // the response follows one cycle after both are held.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= opc_pkg::RESP_OKAY;
    end else begin
      awready <= !aw_held && !(awvalid && awready) && !wr_go && !bvalid;
      wready  <= !w_held && !(wvalid && wready) && !wr_go && !bvalid;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        // A blocked PLL write or an unmapped offset answers with an error.
        bresp   <= (wr_ok && !(wr_pll && !unlock_armed)) ?
                   opc_pkg::RESP_OKAY : opc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel: one read in flight, data one cycle later.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= opc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= is_mapped(araddr) ? opc_pkg::RESP_OKAY :
                                     opc_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_main_pin_take: assert property ( // R02
    $rose(ctrl_main[opc_pkg::OSC_EN_BIT]) |=> crystal_in_pin_takeover)
    else $error("Main oscillator did not take over its input pin.");

  a_main_mask_hold: assert property ( // R06
    $rose(osc_run[0]) |-> !main_clock_gate [*8])
    else $error("Main clock gate opened during start-up.");

  a_main_rdy_time: assert property ( // R06
    $rose(osc_ready[0]) |->
      $past(osc_cnt[0]) == startup_limit($past(osc_sel[0])) - CNT_W'(1))
    else $error("Main ready rose before the start-up count ended.");

  a_ready_event: assert property ( // R12
    $rose(osc_ready[1]) ##1 !wr_icr |=> isr[opc_pkg::ST_SLOW_RDY])
    else $error("Slow ready rise did not raise its event flag.");

  a_mask_set: assert property ( // R08
    wr_ier && wbits[0] && !wr_idr |=> interrupt_mask_reg[0] ##1 interrupt_mask_reg[0])
    else $error("Interrupt enable write did not set the mask.");

  a_slow_sleep: assert property ( // R10
    sleep_osc_off && ctrl_slow[opc_pkg::OSC_EN_BIT] |=> slow_osc_run)
    else $error("Slow oscillator stopped in sleep.");

  a_pll_guard: assert property ( // R18
    wr_pll && !unlock_armed |=> $stable(ctrl_pll))
    else $error("Protected PLL register changed without unlock.");

  a_pll_frozen: assert property ( // R21
    pll_pass && pll_en |=> $stable(ctrl_pll[31:1]))
    else $error("PLL configuration changed while enabled.");

  a_pll_mask: assert property ( // R17
    $rose(pll_run_now) |-> ##1 !pll_clock_gate ##1 !pll_clock_gate)
    else $error("PLL output not masked after start.");

  a_lock_lost: assert property ( // R22
    pll_locked && pll_run_now && !pll_lock_in |=> pll_lost)
    else $error("Loss of PLL lock not flagged.");

  a_rdy_clear: assert property ( // R23
    !osc_run[0] |=> !osc_ready[0] ##1 !main_clock_gate)
    else $error("Main ready stayed set after disable.");

endmodule
`default_nettype wire

// ### dv/opc_partner.sv
// Far-side model: the analog lock detector of the loop.
// Assumes pll_run from the block and a fault command from the bench.
`timescale 1ns/1ps
`default_nettype none
module opc_partner #(
  parameter int LOCK_DLY = 20
) (
  input  wire logic mclk,
  input  wire logic pll_run,
  input  wire logic lose_lock,
  output logic      pll_lock_in
);
  int cnt;

  // Lock comes only after a full settling time of running, never sooner.
  always_ff @(posedge mclk) begin
    if (!pll_run) begin
      cnt <= 0;
    end else if (cnt < LOCK_DLY) begin
      cnt <= cnt + 1;
    end
  end
  // The fault input is the one wrong answer that the bench commands.
  assign pll_lock_in = pll_run && (cnt == LOCK_DLY) && !lose_lock;
endmodule
`default_nettype wire

// ### dv/opc_top_bench.sv
// Self-checking bench for the oscillator and PLL control block.
// Assumes the design top, its package and the lock model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module opc_top_bench;
  logic        mclk = 0, resetn = 0, por_n = 0, brownout_reset_cause = 0;
  logic        sleep_osc_off = 0, lose_lock = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd_q;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0]  rsp;
  wire logic   awready, wready, bvalid, arready, rvalid, irq, pll_lock_in;
  wire logic [1:0]  bresp, rresp, pll_ref_select;
  wire logic   main_osc_crystal_mode, slow_osc_crystal_mode;
  wire logic   slow_primary_pin_takeover;
  wire logic [31:0] rdata;
  wire logic   main_osc_run, crystal_in_pin_takeover, crystal_out_pin_takeover;
  wire logic   main_clock_gate, slow_osc_run, slow_alt_pin_takeover;
  wire logic   slow_clock_gate, khz_clock_gate, pll_run, pll_clock_gate;
  wire logic   rc_slow_clock_out_pin_enable;
  wire logic [3:0]  pll_multiplier, pll_divider;
  wire logic [7:0]  bod_control;
  int          num_errors = 0, checks = 0;

  // A 40 MHz clock.
  always #12.5 mclk = ~mclk;

  opc_top #(.CNT_W(24)) dut (.*);
  opc_partner #(.LOCK_DLY(20)) far (.*);

  // Comparison and bus tasks; each bus task starts one edge on so that no
  // signal is assigned twice in the same time step.
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad = 0, wd = 0;
    int n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 1'h0;
      end
      if (wready && !wd) begin
        wd = 1;
        wvalid <= 1'h0;
      end
    end while (!(bvalid && ad && wd) && n < 50);
    rsp = bresp;
    bready <= 1'h0;
    if (n >= 50) num_errors++;
  endtask

  task automatic rd(input logic [7:0] a);
    bit ad = 0;
    int n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (arready && !ad) begin
        ad = 1;
        arvalid <= 1'h0;
      end
    end while (!(rvalid && ad) && n < 50);
    rd_q = rdata;
    rsp = rresp;
    rready <= 1'h0;
    if (n >= 50) num_errors++;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic rst(input logic por);
    resetn <= 1'h0;
    por_n <= !por;
    cyc(5);
    resetn <= 1'h1;
    por_n <= 1'h1;
    cyc(4);
  endtask

  task automatic t_reset;
    rd(8'h00);
    chk("main ctrl", rd_q, 32'h0000_0000);
    rd(8'h04);
    chk("slow ctrl", rd_q, 32'h0000_0008);
    rd(8'h08);
    chk("pll ctrl", rd_q, 32'h0000_0000);
    rd(8'h30);
    chk("unmapped resp", rsp, 2'h2);
    chk("xin take", crystal_in_pin_takeover, 1'h0);
    chk("rc pin", rc_slow_clock_out_pin_enable, 1'h1);
  endtask

  task automatic t_main;
    wr(8'h14, 32'h0000_0001);
    wr(8'h00, 32'h0000_0003);
    cyc(2);
    chk("xin take", crystal_in_pin_takeover, 1'h1);
    chk("crystal_out_pin take", crystal_out_pin_takeover, 1'h1);
    chk("main mode", main_osc_crystal_mode, 1'h1);
    cyc(6);
    chk("main gate early", main_clock_gate, 1'h0);
    cyc(12);
    chk("main gate", main_clock_gate, 1'h1);
    rd(8'h10);
    chk("main rdy", rd_q[0], 1'h1);
    chk("irq", irq, 1'h1);
    wr(8'h14, 32'h0000_0000);
    rd(8'h1C);
    chk("mask kept", rd_q[0], 1'h1);
    wr(8'h18, 32'h0000_000F);
    wr(8'h24, 32'h0000_000F);
    wr(8'h00, 32'h0000_0001);
    cyc(2);
    chk("crystal_out_pin free", crystal_out_pin_takeover, 1'h0);
    wr(8'h00, 32'h0000_0000);
    rd(8'h10);
    chk("rdy cleared", rd_q[0], 1'h0);
  endtask

  task automatic t_slow;
    wr(8'h04, 32'h0000_0009);
    cyc(20);
    chk("slow gate", slow_clock_gate, 1'h1);
    chk("khz gate", khz_clock_gate, 1'h0);
    chk("pri pins", slow_primary_pin_takeover, 1'h1);
    rd(8'h10);
    chk("slow rdy", rd_q[1], 1'h1);
    chk("irq masked", irq, 1'h0);
    wr(8'h04, 32'h0000_001F);
    cyc(2);
    chk("khz on", khz_clock_gate, 1'h1);
    chk("slow mode", slow_osc_crystal_mode, 1'h1);
    chk("alt pins", slow_alt_pin_takeover, 1'h1);
    wr(8'h00, 32'h0000_0003);
    sleep_osc_off <= 1'h1;
    cyc(3);
    chk("sleep main", main_osc_run, 1'h0);
    chk("sleep slow", slow_osc_run, 1'h1);
    sleep_osc_off <= 1'h0;
    cyc(3);
    chk("wake main", main_osc_run, 1'h1);
    chk("wake gate", main_clock_gate, 1'h0);
    wr(8'h2C, 32'h0000_005A);
    brownout_reset_cause <= 1'h1;
    fork
      rst(0);
      begin
        cyc(3);
        chk("slow in reset", slow_osc_run, 1'h1);
      end
    join
    brownout_reset_cause <= 1'h0;
    rd(8'h04);
    chk("slow kept", rd_q, 32'h0000_001F);
    chk("bod kept", bod_control, 8'h5A);
    chk("main off", main_osc_run, 1'h0);
    rst(0);
    chk("bod cleared", bod_control, 8'h00);
    rst(1);
    rd(8'h04);
    chk("slow por", rd_q, 32'h0000_0008);
  endtask

  task automatic t_pll;
    wr(8'h08, 32'h0000_0103);
    chk("locked resp", rsp, 2'h2);
    wr(8'h0C, 32'hAA00_0008);
    wr(8'h08, 32'h0000_0103);
    cyc(2);
    chk("pll run", pll_run, 1'h1);
    chk("pll gate early", pll_clock_gate, 1'h0);
    chk("pll ref", pll_ref_select, 2'h1);
    cyc(25);
    chk("pll gate", pll_clock_gate, 1'h1);
    wr(8'h0C, 32'hAA00_0008);
    wr(8'h08, 32'h0000_0F03);
    rd(8'h08);
    chk("pll frozen", rd_q, 32'h0000_0103);
    lose_lock <= 1'h1;
    cyc(3);
    rd(8'h10);
    chk("lock lost", rd_q[3:2], 2'h2);
    lose_lock <= 1'h0;
    wr(8'h0C, 32'hAA00_0008);
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'hAA00_0008);
    wr(8'h08, 32'h000F_0F00);
    cyc(2);
    chk("pll mul", pll_multiplier, 4'hF);
    chk("pll div", pll_divider, 4'hF);
  endtask

  task automatic end_sim;
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    rst(1);
    t_reset;
    t_main;
    t_slow;
    t_pll;
    end_sim;
  end

  // Watchdog: the tests need well under 2000 cycles.
  initial begin
    #500000;
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
